// ===== design/gcs_regs.sv
`include "gcs_map.svh"
`timescale 1ns/1ns
`default_nettype none

module gcs_regs #(
    parameter logic [10:0] IDENT_CODE = 11'h5A3, // arbitrary value
    parameter logic        LOW_VOLT   = 1'b0
) (
    input  wire logic       clk_i,
    input  wire logic       sys_rst_i,
    input  wire logic       restart_i,
    input  wire logic       spi_sck_i,
    input  wire logic       spi_sdi_i,
    input  wire logic       spi_cs_n_i,
    output logic            spi_sdo_o,
    output logic            spi_sdo_oe_o,
    input  wire logic [3:0] bus_failure_diagnosis_i,
    input  wire logic       en_function_i,
    input  wire logic [11:0] int_enable_fb_i,
    input  wire logic [11:0] sys_config_fb_i,
    input  wire logic [11:0] phy_control_fb_i,
    output logic            en_o,
    output logic            dev_mode_init_o,
    output logic            fault_output_emulation_o,
    output logic [1:0]      watchdog_prescale_o,
    output logic [2:0]      watchdog_scale_x2_o,
    output logic [1:0]      supply_reset_threshold_o,
    output logic [6:0]      supply_reset_pct_o,
    output logic [11:0]     scratch_bits_0_o,
    output logic [11:0]     scratch_bits_1_o
);

    // ==========================================================
    // pin synchronisers
    logic sck_s;
    logic sdi_s;
    logic csn_s;

    gcs_sync #(.RESET_VAL(1'b0)) u_sync_sck (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .d_i       (spi_sck_i),
        .q_o       (sck_s)
    );
    gcs_sync #(.RESET_VAL(1'b0)) u_sync_sdi (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .d_i       (spi_sdi_i),
        .q_o       (sdi_s)
    );
    gcs_sync #(.RESET_VAL(1'b1)) u_sync_csn (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .d_i       (spi_cs_n_i),
        .q_o       (csn_s)
    );

    // ==========================================================
    // frame engine
    gcs_pkg::gcs_state_t state;
    gcs_pkg::gcs_state_t next_state;
    logic        sck_q;
    logic        csn_q;
    logic [15:0] rx;
    logic [15:0] next_rx;
    logic [15:0] tx;
    logic [15:0] next_tx;
    logic [4:0]  bit_cnt;
    logic [4:0]  next_bit_cnt;
    logic [11:0] readback;
    logic        sck_rise;
    logic        sck_fall;
    logic        cs_start;
    logic        cs_end;
    logic        hdr_done;

    assign sck_rise = sck_s & ~sck_q;
    assign sck_fall = ~sck_s & sck_q;
    assign cs_start = csn_q & ~csn_s;
    assign cs_end   = ~csn_q & csn_s;
    assign hdr_done = (state == gcs_pkg::GCS_SHIFT) && sck_rise
                      && (bit_cnt == `GCS_HDR_BITS - 5'h01);

    // readback is chosen once address, select and flag are in
    always_comb begin
        readback = 12'h000;
        if (next_rx[3:2] == `GCS_ADDR_GLOBAL) begin
            readback = next_rx[1] ? {2'h0, dev_mode_init_o,
                                     fault_output_emulation_o, 1'b0,
                                     watchdog_prescale_o,
                                     supply_reset_threshold_o, 3'h0}
                                  : int_enable_fb_i;
        end else if (next_rx[3:2] == `GCS_ADDR_SCR0) begin
            readback = next_rx[1] ? scratch_bits_0_o : sys_config_fb_i;
        end else if (next_rx[3:2] == `GCS_ADDR_SCR1) begin
            readback = next_rx[1] ? scratch_bits_1_o : phy_control_fb_i;
        end
    end

    always_comb begin
        next_state   = state;
        next_rx      = rx;
        next_tx      = tx;
        next_bit_cnt = bit_cnt;
        case (state)
            gcs_pkg::GCS_IDLE: begin
                if (cs_start) begin
                    next_state   = gcs_pkg::GCS_SHIFT;
                    next_rx      = 16'h0000;
                    next_tx      = 16'h0000;
                    next_bit_cnt = 5'h00;
                end
            end
            gcs_pkg::GCS_SHIFT: begin
                if (cs_end) begin
                    // short or long frames are dropped without a write
                    next_state = (bit_cnt == `GCS_FRAME_BITS)
                                 ? gcs_pkg::GCS_DONE : gcs_pkg::GCS_IDLE;
                end else begin
                    if (sck_rise) begin
                        next_rx = {rx[14:0], sdi_s};
                        if (bit_cnt != 5'h1F) begin
                            next_bit_cnt = bit_cnt + 5'h01;
                        end
                    end
                    if (hdr_done) begin
                        next_tx = {1'b0, readback, 3'h0};
                    end else if (sck_fall) begin
                        next_tx = {tx[14:0], 1'b0};
                    end
                end
            end
            gcs_pkg::GCS_DONE: begin
                next_state = gcs_pkg::GCS_IDLE;
            end
            default: begin
                next_state = gcs_pkg::GCS_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            state   <= gcs_pkg::GCS_IDLE;
            sck_q   <= 1'b0;
            csn_q   <= 1'b1;
            rx      <= 16'h0000;
            tx      <= 16'h0000;
            bit_cnt <= 5'h00;
        end else begin
            state   <= next_state;
            sck_q   <= sck_s;
            csn_q   <= csn_s;
            rx      <= next_rx;
            tx      <= next_tx;
            bit_cnt <= next_bit_cnt;
        end
    end

    assign spi_sdo_o    = tx[15];
    assign spi_sdo_oe_o = ~csn_s;

    // ==========================================================
    // register bank
    logic        wr_en;
    logic [1:0]  wr_addr;
    logic        next_dev_mode;
    logic        next_emul;
    logic [1:0]  next_presc;
    logic [1:0]  next_thr;
    logic [11:0] next_scr0;
    logic [11:0] next_scr1;
    logic        next_en;

    assign wr_en   = (state == gcs_pkg::GCS_DONE) && !rx[`GCS_RO_BIT];
    assign wr_addr = rx[`GCS_ADDR_HI:`GCS_ADDR_LO];

    always_comb begin
        next_dev_mode = dev_mode_init_o;
        next_emul     = fault_output_emulation_o;
        next_presc    = watchdog_prescale_o;
        next_thr      = supply_reset_threshold_o;
        next_scr0     = scratch_bits_0_o;
        next_scr1     = scratch_bits_1_o;
        // reserved config bits are dropped, so they read as zero
        if (wr_en && wr_addr == `GCS_ADDR_GLOBAL) begin
            next_dev_mode = rx[`GCS_DEVMODE_BIT];
            next_emul     = rx[`GCS_EMUL_BIT];
            next_presc    = rx[`GCS_PRESC_HI:`GCS_PRESC_LO];
            next_thr      = rx[`GCS_THR_HI:`GCS_THR_LO];
        end else if (wr_en && wr_addr == `GCS_ADDR_SCR0) begin
            next_scr0 = {1'b1, rx[10:0]};
        end else if (wr_en && wr_addr == `GCS_ADDR_SCR1) begin
            next_scr1 = rx[11:0];
        end
        // restart clears the threshold even over a global config write landing in the same cycle
        if (restart_i) begin
            next_thr = 2'h0;
        end
        next_en = fault_output_emulation_o
                  ? (bus_failure_diagnosis_i == `GCS_BUS_FAILURE_DIAGNOSIS_OK)
                  : en_function_i;
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            dev_mode_init_o          <= 1'(`GCS_GCFG_RST >> `GCS_DEVMODE_BIT);
            fault_output_emulation_o <= 1'b0;
            watchdog_prescale_o      <= 2'h0;
            supply_reset_threshold_o <= 2'h0;
            scratch_bits_0_o         <= {1'b0, IDENT_CODE};
            scratch_bits_1_o         <= `GCS_SCR1_RST;
            en_o                     <= 1'b0;
        end else begin
            dev_mode_init_o          <= next_dev_mode;
            fault_output_emulation_o <= next_emul;
            watchdog_prescale_o      <= next_presc;
            supply_reset_threshold_o <= next_thr;
            scratch_bits_0_o         <= next_scr0;
            scratch_bits_1_o         <= next_scr1;
            en_o                     <= next_en;
        end
    end

    // ==========================================================
    // decoded settings
    always_comb begin
        case (watchdog_prescale_o)
            2'h0:    watchdog_scale_x2_o = `GCS_SCALE_00;
            2'h1:    watchdog_scale_x2_o = `GCS_SCALE_01;
            2'h2:    watchdog_scale_x2_o = `GCS_SCALE_10;
            default: watchdog_scale_x2_o = `GCS_SCALE_11;
        endcase
        // the low-voltage variant lacks 70 percent, so it falls back to 90
        case (supply_reset_threshold_o)
            2'h1:    supply_reset_pct_o = `GCS_PCT_80;
            2'h2:    supply_reset_pct_o = LOW_VOLT ? `GCS_PCT_90
                                                   : `GCS_PCT_70;
            default: supply_reset_pct_o = `GCS_PCT_90;
        endcase
    end

    // ==========================================================
    // checks
    property p_gcfg_write;
        @(posedge clk_i) disable iff (sys_rst_i)
        (wr_en && wr_addr == `GCS_ADDR_GLOBAL && !restart_i)
        |=> dev_mode_init_o == $past(rx[`GCS_DEVMODE_BIT])
            && watchdog_prescale_o == $past(rx[6:5]);
    endproperty
    a_gcfg_write: assert property (p_gcfg_write)
        else $error("global config not written from frame");
    property p_ro_keeps;
        @(posedge clk_i) disable iff (sys_rst_i)
        (state == gcs_pkg::GCS_DONE && rx[`GCS_RO_BIT] && !restart_i)
        |=> $stable(scratch_bits_0_o) && $stable(scratch_bits_1_o)
            && $stable(supply_reset_threshold_o);
    endproperty
    a_ro_keeps: assert property (p_ro_keeps)
        else $error("read-only frame changed a register");
    property p_flag_set;
        @(posedge clk_i) disable iff (sys_rst_i)
        (wr_en && wr_addr == `GCS_ADDR_SCR0)
        |=> scratch_bits_0_o[`GCS_FLAG_BIT]
            && scratch_bits_0_o[10:0] == $past(rx[10:0]);
    endproperty
    a_flag_set: assert property (p_flag_set)
        else $error("scratch 0 write did not set flag");
    property p_scr1_write;
        @(posedge clk_i) disable iff (sys_rst_i)
        (wr_en && wr_addr == `GCS_ADDR_SCR1)
        |=> scratch_bits_1_o == $past(rx[11:0]);
    endproperty
    a_scr1_write: assert property (p_scr1_write)
        else $error("scratch 1 not written");
    property p_en_emul;
        @(posedge clk_i) disable iff (sys_rst_i)
        fault_output_emulation_o
        |=> en_o == ($past(bus_failure_diagnosis_i) == `GCS_BUS_FAILURE_DIAGNOSIS_OK);
    endproperty
    a_en_emul: assert property (p_en_emul)
        else $error("enable output ignores diagnosis");
    property p_en_plain;
        @(posedge clk_i) disable iff (sys_rst_i)
        !fault_output_emulation_o |=> en_o == $past(en_function_i);
    endproperty
    a_en_plain: assert property (p_en_plain)
        else $error("enable output lost its enable role");
    property p_restart_thr;
        @(posedge clk_i) disable iff (sys_rst_i)
        restart_i |=> supply_reset_threshold_o == 2'h0
            && watchdog_prescale_o
               == (($past(wr_en) && $past(wr_addr) == `GCS_ADDR_GLOBAL)
                   ? $past(rx[6:5]) : $past(watchdog_prescale_o));
    endproperty
    a_restart_thr: assert property (p_restart_thr)
        else $error("restart handling of config wrong");
    property p_rb_load;
        @(posedge clk_i) disable iff (sys_rst_i)
        (hdr_done && !cs_end) |=> tx[14:3] == $past(readback)
                                  && !spi_sdo_o;
    endproperty
    a_rb_load: assert property (p_rb_load)
        else $error("readback not loaded after header");
    property p_short_frame;
        @(posedge clk_i) disable iff (sys_rst_i)
        (state == gcs_pkg::GCS_SHIFT && cs_end && bit_cnt != `GCS_FRAME_BITS)
        |=> state == gcs_pkg::GCS_IDLE ##1 state == gcs_pkg::GCS_IDLE;
    endproperty
    a_short_frame: assert property (p_short_frame)
        else $error("partial frame was committed");

endmodule

`default_nettype wire

// ===== design/gcs_map.svh
`ifndef GCS_MAP_SVH
`define GCS_MAP_SVH

// frame layout, MSB first
`define GCS_FRAME_BITS     5'h10
`define GCS_HDR_BITS       5'h04
`define GCS_ADDR_HI        15
`define GCS_ADDR_LO        14
`define GCS_RRS_BIT        13
`define GCS_RO_BIT         12

// register addresses
`define GCS_ADDR_NONE      2'h0
`define GCS_ADDR_GLOBAL    2'h1
`define GCS_ADDR_SCR0      2'h2
`define GCS_ADDR_SCR1      2'h3

// global configuration fields, then the scratch 0 flag bit
`define GCS_DEVMODE_BIT    9
`define GCS_EMUL_BIT       8
`define GCS_PRESC_HI       6
`define GCS_PRESC_LO       5
`define GCS_THR_HI         4
`define GCS_THR_LO         3
`define GCS_FLAG_BIT       11

// reset values and the bus failure diagnosis ok code
`define GCS_GCFG_RST       12'h000
`define GCS_SCR1_RST       12'h000
`define GCS_BUS_FAILURE_DIAGNOSIS_OK       4'h0

// threshold in percent of nominal
`define GCS_PCT_90         7'h5A
`define GCS_PCT_80         7'h50
`define GCS_PCT_70         7'h46

// prescale factor times two: 1, 1.5, 2.5, 3.5
`define GCS_SCALE_00       3'h2
`define GCS_SCALE_01       3'h3
`define GCS_SCALE_10       3'h5
`define GCS_SCALE_11       3'h7

`endif

// ===== design/gcs_pkg.sv
`default_nettype none

package gcs_pkg;

    typedef enum logic [1:0] {
        GCS_IDLE  = 2'h0,
        GCS_SHIFT = 2'h1,
        GCS_DONE  = 2'h3
    } gcs_state_t;

endpackage

`default_nettype wire

// ===== design/gcs_sync.sv
`timescale 1ns/1ns
`default_nettype none

module gcs_sync #(
    parameter logic RESET_VAL = 1'b0
) (
    input  wire logic clk_i,
    input  wire logic sys_rst_i,
    input  wire logic d_i,
    output logic      q_o
);

    logic meta;

    // meta feeds only the second stage
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            meta <= RESET_VAL;
            q_o  <= RESET_VAL;
        end else begin
            meta <= d_i;
            q_o  <= meta;
        end
    end

endmodule

`default_nettype wire

// ===== verif/gcs_host.sv
`timescale 1ns/1ns
`default_nettype none

// ==========================================================
// host side of the serial register link
module gcs_host (
    input  wire logic clk_i,
    input  wire logic sdo_i,
    output logic      sck_o,
    output logic      sdi_o,
    output logic      cs_n_o
);
    // sck idles low between frames, six clk per level
    initial begin
        sck_o  = 1'b0;
        sdi_o  = 1'b1;
        cs_n_o = 1'b1;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask

    // readback comes in while the request goes out
    // n below 16 sends a cut frame, which must not write anything
    task automatic xfer(input  logic [15:0] f,
                        input  int          n,
                        output logic [15:0] rd);
        cs_n_o = 1'b0;
        tick(6);
        for (int k = 15; k >= 16 - n; k--) begin
            sdi_o = f[k];
            tick(6);
            sck_o = 1'b1;
            rd[k] = sdo_i;
            tick(6);
            sck_o = 1'b0;
        end
        tick(6);
        cs_n_o = 1'b1;
        // released data line must not keep the last bit
        sdi_o = ~f[0];
        tick(10);
    endtask
endmodule

`default_nettype wire

// ===== verif/gcs_regs_tb.sv
`timescale 1ns/1ns
`default_nettype none

module gcs_regs_tb;
    localparam logic [10:0] ID = 11'h2C7; // arbitrary value
    logic        clk_i     = 1'b0;
    logic        sys_rst_i = 1'b1;
    logic        restart_i = 1'b0;
    logic        en_fn     = 1'b0;
    logic [3:0]  bfd       = 4'h0;
    logic [11:0] ie_fb     = 12'hA11;
    logic [11:0] sc_fb     = 12'h5B2;
    logic [11:0] ph_fb     = 12'h3C4;
    logic        sck, sdi, cs_n, sdo, en_o, dev, emul;
    logic [1:0]  presc, thr;
    logic [2:0]  scale;
    logic [6:0]  pct;
    logic [11:0] s0, s1, rd;
    logic        sdo_oe;
    logic        sdo_line;
    logic [6:0]  pct_lv;
    int          fails  = 0;
    int          checks = 0;

    always #4 clk_i = ~clk_i;

    gcs_regs #(.IDENT_CODE(ID)) gcs_regs_i (
        .clk_i                   (clk_i),
        .sys_rst_i               (sys_rst_i),
        .restart_i               (restart_i),
        .spi_sck_i               (sck),
        .spi_sdi_i               (sdi),
        .spi_cs_n_i              (cs_n),
        .spi_sdo_o               (sdo),
        .spi_sdo_oe_o            (sdo_oe),
        .bus_failure_diagnosis_i (bfd),
        .en_function_i           (en_fn),
        .int_enable_fb_i         (ie_fb),
        .sys_config_fb_i         (sc_fb),
        .phy_control_fb_i        (ph_fb),
        .en_o                    (en_o),
        .dev_mode_init_o         (dev),
        .fault_output_emulation_o(emul),
        .watchdog_prescale_o     (presc),
        .watchdog_scale_x2_o     (scale),
        .supply_reset_threshold_o(thr),
        .supply_reset_pct_o      (pct),
        .scratch_bits_0_o        (s0),
        .scratch_bits_1_o        (s1)
    );

    // a released line shows the inverse, so a late enable spoils reads
    assign sdo_line = sdo_oe ? sdo : ~sdo;

    gcs_host host_i (
        .clk_i (clk_i),
        .sdo_i (sdo_line),
        .sck_o (sck),
        .sdi_o (sdi),
        .cs_n_o(cs_n)
    );

    // low-voltage build: threshold code 10 must fall back to 90 percent
    gcs_regs #(.LOW_VOLT(1'b1)) gcs_regs_lv_i (
        .clk_i                   (clk_i),
        .sys_rst_i               (sys_rst_i),
        .restart_i               (restart_i),
        .spi_sck_i               (sck),
        .spi_sdi_i               (sdi),
        .spi_cs_n_i              (cs_n),
        .spi_sdo_o               (),
        .spi_sdo_oe_o            (),
        .bus_failure_diagnosis_i (bfd),
        .en_function_i           (en_fn),
        .int_enable_fb_i         (ie_fb),
        .sys_config_fb_i         (sc_fb),
        .phy_control_fb_i        (ph_fb),
        .en_o                    (),
        .dev_mode_init_o         (),
        .fault_output_emulation_o(),
        .watchdog_prescale_o     (),
        .watchdog_scale_x2_o     (),
        .supply_reset_threshold_o(),
        .supply_reset_pct_o      (pct_lv),
        .scratch_bits_0_o        (),
        .scratch_bits_1_o        ()
    );

    // ==========================================================
    // helpers
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask

    task automatic chk(input string nm, input logic [11:0] e,
                       input logic [11:0] g);
        checks++;
        if (g !== e) begin
            fails++;
            $display("CHECK FAILED %s exp %h got %h", nm, e, g);
        end
    endtask

    task automatic acc(input logic [1:0] a, input logic s,
                       input logic ro, input logic [11:0] d);
        logic [15:0] r;
        host_i.xfer({a, s, ro, d}, 16, r);
        rd = r[11:0];
    endtask

    function automatic logic [11:0] cfg();
        return {2'h0, dev, emul, 1'b0, presc, thr, 3'h0};
    endfunction

    task automatic give_verdict();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // ==========================================================
    // scenarios
    task automatic t_por();
        chk("s0", {1'b0, ID}, s0);
        chk("cfg", 12'h000, cfg());
        chk("s1", 12'h000, s1);
        chk("en", 12'h000, 12'(en_o));
        chk("oe", 12'h000, 12'(sdo_oe));
        acc(2'h2, 1'b1, 1'b1, 12'hFFF);
        chk("rd s0", {1'b0, ID}, rd);
        chk("s0 ro", {1'b0, ID}, s0);
    endtask

    task automatic t_cfg();
        logic [2:0]  sx[4] = '{3'h2, 3'h3, 3'h5, 3'h7};
        logic [6:0]  px[4] = '{7'h5A, 7'h50, 7'h46, 7'h5A};
        logic [11:0] d;
        for (int c = 0; c < 4; c++) begin
            d = {2'h0, c[0], 2'h0, 2'(c), 2'(3 - c), 3'h0};
            acc(2'h1, 1'b1, 1'b0, d);
            chk("dev", 12'(c[0]), 12'(dev));
            chk("scale", 12'(sx[c]), 12'(scale));
            chk("pct", 12'(px[3 - c]), 12'(pct));
            chk("pct lv", 12'((c == 1) ? 7'h5A : px[3 - c]),
                12'(pct_lv));
            acc(2'h1, 1'b1, 1'b1, 12'h000);
            chk("rd cfg", d, rd);
        end
        acc(2'h1, 1'b0, 1'b1, 12'h378);
        chk("rd ie", ie_fb, rd);
        chk("ro cfg", d, cfg());
    endtask

    task automatic t_emul();
        acc(2'h1, 1'b1, 1'b0, 12'h100);
        chk("emul", 12'h001, 12'(emul));
        chk("en ok", 12'h001, 12'(en_o));
        bfd = 4'h8;
        en_fn = 1'b1;
        tick(4);
        chk("en fail", 12'h000, 12'(en_o));
        acc(2'h1, 1'b1, 1'b0, 12'h000);
        chk("en fn1", 12'h001, 12'(en_o));
        en_fn = 1'b0;
        tick(4);
        chk("en fn0", 12'h000, 12'(en_o));
    endtask

    task automatic t_scr();
        acc(2'h2, 1'b1, 1'b1, 12'h123);
        chk("s0 keep", {1'b0, ID}, s0);
        acc(2'h2, 1'b0, 1'b0, 12'h4F0);
        chk("rd sys", sc_fb, rd);
        chk("s0 flag", 12'hCF0, s0);
        acc(2'h2, 1'b1, 1'b1, 12'h000);
        chk("rd s0", 12'hCF0, rd);
        acc(2'h3, 1'b1, 1'b0, 12'hA5C);
        chk("s1", 12'hA5C, s1);
        acc(2'h3, 1'b0, 1'b1, 12'h000);
        chk("rd phy", ph_fb, rd);
        chk("s1 ro", 12'hA5C, s1);
        acc(2'h3, 1'b1, 1'b1, 12'h000);
        chk("rd s1", 12'hA5C, rd);
    endtask

    // address 00 reaches nothing: no write, reads zero
    task automatic t_addr0();
        acc(2'h0, 1'b1, 1'b0, 12'hFFF);
        acc(2'h0, 1'b1, 1'b1, 12'h000);
        chk("rd a0", 12'h000, rd);
        chk("s0 a0", 12'hCF0, s0);
        chk("s1 a0", 12'hA5C, s1);
    endtask

    // a cut frame must leave every register alone
    task automatic t_short();
        logic [15:0] r;
        host_i.xfer({2'h3, 1'b1, 1'b0, 12'h000}, 8, r);
        chk("s1 cut", 12'hA5C, s1);
        acc(2'h3, 1'b1, 1'b1, 12'h000);
        chk("rd cut", 12'hA5C, rd);
    endtask

    task automatic t_restart();
        acc(2'h1, 1'b1, 1'b0, 12'h368);
        restart_i = 1'b1;
        tick(1);
        restart_i = 1'b0;
        tick(2);
        chk("cfg rs", 12'h360, cfg());
        chk("s1 rs", 12'hA5C, s1);
        sys_rst_i = 1'b1;
        tick(2);
        sys_rst_i = 1'b0;
        tick(4);
        t_por();
    endtask

    // ==========================================================
    // main sequence and watchdog
    initial begin
        tick(2);
        sys_rst_i = 1'b0;
        tick(4);
        t_por();
        t_cfg();
        t_emul();
        t_scr();
        t_addr0();
        t_short();
        t_restart();
        give_verdict();
    end

    // about 25 frames of some 220 clk each fit well inside this
    initial begin
        #200000;
        fails++;
        give_verdict();
    end
endmodule

`default_nettype wire
